// file: logic/ccm_consts.vh
// constants for the coulomb counter monitor core
// Behaviour
// - negative sense counts discharge per 3.05 uVh
// - positive sense counts charge per 3.05 uVh
// - active time counter ticks 4096 per hour
// - both time counters 16 bits, wrap past ffff
// - time rollover sets slow flag, 1/256 rate
// - self-discharge hourly at 25C, doubles per 10C
// - sleep command plus quiet sense stops acquisition; with wake threshold field 0 the command alone does
// - asleep, timebase keeps running to update self-discharge
// - any serial line edge ends sleep
// - 3-bit wake threshold field selects quiet level
// - normal all run, sleep self-discharge, hibernate none
// - power-on reset enters hibernate, release exits
// - sense offset removed automatically and continuously
// - host writes 1 in clear register to zero counter
// - clear bit returns to zero when done
// - clearing time counter drops slow flag, default rate
// - die temperature in kelvin in high/low pair
// - 11-bit voltage, 3 bits high, 8 bits low
// - voltage high bits 7..3 hold sign-magnitude offset
// - 128 byte locations: rom, ram, flash, specials
`ifndef CCM_CONSTS_VH
`define CCM_CONSTS_VH
`define CCM_CLK_NS 20
`define CCM_TICK_NS 878906250
`define CCM_SAMPLE_HZ 1024
`define CCM_QUANT_UVH_X100 305
`define CCM_SLOW_DIV 8'hFF
`define CCM_CNT_MAX 16'hFFFF
`define CCM_SD_BASE 16'h0200
`define CCM_CMD_SLEEP 8'hF6
`define CCM_ERASED 8'hFF
`define CCM_WOE1_UV 19'h0_0DBC
`define CCM_WOE2_UV 19'h0_06DE
`define CCM_WOE3_UV 19'h0_0494
`define CCM_WOE4_UV 19'h0_036F
`define CCM_WOE5_UV 19'h0_02BF
`define CCM_WOE6_UV 19'h0_024A
`define CCM_WOE7_UV 19'h0_01F6
`define CCM_K_55C 11'h148
`define CCM_K_45C 11'h13E
`define CCM_K_35C 11'h134
`define CCM_K_25C 11'h12A
`define CCM_K_15C 11'h120
`define CCM_K_5C 11'h116
`define CCM_A_RAM_TOP 7'h1F
`define CCM_A_FLASH_TOP 7'h5F
`define CCM_A_TEMPL 7'h60
`define CCM_A_TEMPH 7'h61
`define CCM_A_FCMD 7'h62
`define CCM_A_CLR 7'h63
`define CCM_A_MODE 7'h64
`define CCM_A_CTCL 7'h65
`define CCM_A_CTCH 7'h66
`define CCM_A_DTCL 7'h67
`define CCM_A_DTCH 7'h68
`define CCM_A_SCRL 7'h69
`define CCM_A_SCRH 7'h6A
`define CCM_A_CCRL 7'h6B
`define CCM_A_CCRH 7'h6C
`define CCM_A_DCRL 7'h6D
`define CCM_A_DCRH 7'h6E
`define CCM_A_FPD 7'h6F
`define CCM_A_FPA 7'h70
`define CCM_A_CELL_VOLTAGE_LOW 7'h71
`define CCM_A_CELL_VOLTAGE_HIGH_OFFSET 7'h72
`define CCM_A_RSV_TOP 7'h77
`define CCM_CLR_DCR 0
`define CCM_CLR_CCR 1
`define CCM_CLR_SCR 2
`define CCM_CLR_DTC 3
`define CCM_CLR_CTC 4
`define CCM_MODE_POR 0
`define CCM_MODE_SLD 4
`define CCM_MODE_SLC 5
`endif

// file: logic/ccm_core.v
// coulomb counter monitor core: counters, power states, register space
`include "ccm_consts.vh"
`default_nettype none
module ccm_core #(
   parameter [31:0] TICK_CYCLES = `CCM_TICK_NS / `CCM_CLK_NS,
   parameter [31:0] QUANTUM = `CCM_QUANT_UVH_X100 * 36 * `CCM_SAMPLE_HZ,
   parameter [7:0] ID_DEVICE = 8'h5A, // arbitrary value
   parameter [7:0] ID_GAIN = 8'h00,
   parameter [39:0] ID_RANDOM = 40'h00_0000_0000 // arbitrary value
) (
   input wire clk,
   input wire reset,
   input wire por_in,
   input wire single_wire_serial_line,
   input wire [17:0] sense_sample,
   input wire sense_valid,
   input wire [17:0] sense_zero,
   input wire sense_zero_valid,
   input wire [10:0] cell_voltage_input,
   input wire [4:0] cell_voltage_ofs,
   input wire cell_voltage_valid,
   input wire [10:0] die_temp_in,
   input wire die_temp_valid,
   input wire [6:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg in_sleep,
   output reg in_hibernate
);
   localparam [3:0] ST_NORM = 4'b0001;
   localparam [3:0] ST_PEND = 4'b0010;
   localparam [3:0] ST_SLEEP = 4'b0100;
   localparam [3:0] ST_HIB = 4'b1000;

   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [2:0] wsync_r;
   reg [2:0] psync_r;
   reg wire_st_r;
   reg por_st_r;
   reg [17:0] offset_r;
   reg [31:0] dacc_r;
   reg [31:0] cacc_r;
   reg [15:0] dcount_r;
   reg [15:0] ccount_r;
   reg [15:0] sdcount_r;
   reg [15:0] dtime_r;
   reg [15:0] ctime_r;
   reg [7:0] ddiv_r;
   reg [7:0] cdiv_r;
   reg [15:0] sddiv_r;
   reg [31:0] tick_cnt_r;
   reg tick_r;
   reg dis_act_r;
   reg chg_act_r;
   reg quiet_r;
   reg [4:0] clr_r;
   reg [7:0] mode_r;
   reg [7:0] fcmd_r;
   reg [7:0] fpa_r;
   reg [7:0] fpd_r;
   reg [10:0] volt_r;
   reg [4:0] vofs_r;
   reg [10:0] temp_r;
   reg [7:0] ram_r [0:31];
   reg [18:0] woe_thr;
   reg [2:0] sd_shift;
   reg [7:0] rd_nxt;

   wire wire_edge = (wsync_r[1] == wsync_r[2]) && (wsync_r[2] != wire_st_r);
   wire por_next = (psync_r[1] == psync_r[2]) ? psync_r[2] : por_st_r;
   wire run_main = state_r[0] | state_r[1];
   wire run_sd = run_main | state_r[2];
   wire wr_fcmd = reg_wr && (reg_addr == `CCM_A_FCMD);
   wire wr_clr = reg_wr && (reg_addr == `CCM_A_CLR);
   wire wr_mode = reg_wr && (reg_addr == `CCM_A_MODE);
   wire signed [18:0] diff = {sense_sample[17], sense_sample} - {offset_r[17], offset_r};
   wire [18:0] mag = diff[18] ? (~diff + 19'h0_0001) : diff;
   wire [31:0] dsum = dacc_r + {13'h0000, mag};
   wire [31:0] csum = cacc_r + {13'h0000, mag};
   wire [15:0] sd_period = `CCM_SD_BASE << sd_shift;
   wire d_step = tick_r && run_main && dis_act_r &&
      (!mode_r[`CCM_MODE_SLD] || ddiv_r == `CCM_SLOW_DIV);
   wire c_step = tick_r && run_main && chg_act_r &&
      (!mode_r[`CCM_MODE_SLC] || cdiv_r == `CCM_SLOW_DIV);

   // wake threshold lookup, sense units of 1 uV
   always @* begin
      case (mode_r[3:1])
         3'h1: woe_thr = `CCM_WOE1_UV;
         3'h2: woe_thr = `CCM_WOE2_UV;
         3'h3: woe_thr = `CCM_WOE3_UV;
         3'h4: woe_thr = `CCM_WOE4_UV;
         3'h5: woe_thr = `CCM_WOE5_UV;
         3'h6: woe_thr = `CCM_WOE6_UV;
         3'h7: woe_thr = `CCM_WOE7_UV;
         default: woe_thr = 19'h0_0000;
      endcase
   end

   // self-discharge period in ticks: 4096 at 25C, halves per 10C up
   always @* begin
      if (temp_r >= `CCM_K_55C) begin
         sd_shift = 3'd0;
      end else if (temp_r >= `CCM_K_45C) begin
         sd_shift = 3'd1;
      end else if (temp_r >= `CCM_K_35C) begin
         sd_shift = 3'd2;
      end else if (temp_r >= `CCM_K_25C) begin
         sd_shift = 3'd3;
      end else if (temp_r >= `CCM_K_15C) begin
         sd_shift = 3'd4;
      end else if (temp_r >= `CCM_K_5C) begin
         sd_shift = 3'd5;
      end else begin
         sd_shift = 3'd6;
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_NORM: begin
            if (wr_fcmd && reg_wdata == `CCM_CMD_SLEEP) begin
               state_nxt = ST_PEND;
            end
         end
         ST_PEND: begin
            if (wire_edge) begin
               state_nxt = ST_NORM;
            end else if (mode_r[3:1] == 3'h0 || quiet_r) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wire_edge) begin
               state_nxt = ST_NORM;
            end
         end
         ST_HIB: begin
            if (!por_st_r) begin
               state_nxt = ST_NORM;
            end
         end
         default: state_nxt = ST_HIB;
      endcase
      if (por_st_r) begin
         state_nxt = ST_HIB;
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_HIB;
         wsync_r <= 3'b111;
         psync_r <= 3'b111;
         wire_st_r <= 1'b1;
         por_st_r <= 1'b1;
         in_sleep <= 1'b0;
         in_hibernate <= 1'b1;
      end else begin
         state_r <= state_nxt;
         wsync_r <= {wsync_r[1:0], single_wire_serial_line};
         psync_r <= {psync_r[1:0], por_in};
         if (wsync_r[1] == wsync_r[2]) begin
            wire_st_r <= wsync_r[2];
         end
         por_st_r <= por_next;
         in_sleep <= state_nxt[2];
         in_hibernate <= state_nxt[3];
      end
   end

   // timebase: one tick per 1/4096 hour, stopped in hibernate
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else if (!run_sd) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_CYCLES - 32'h0000_0001) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r <= 1'b0;
      end
   end

   // charge integration with offset removal
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         offset_r <= 18'h0_0000;
         dacc_r <= 32'h0000_0000;
         cacc_r <= 32'h0000_0000;
         dcount_r <= 16'h0000;
         ccount_r <= 16'h0000;
         dis_act_r <= 1'b0;
         chg_act_r <= 1'b0;
         quiet_r <= 1'b0;
      end else begin
         if (sense_zero_valid) begin
            offset_r <= sense_zero;
         end
         if (sense_valid) begin
            dis_act_r <= diff[18];
            chg_act_r <= !diff[18] && (diff != 19'h0_0000);
            quiet_r <= mag < woe_thr;
         end
         if (sense_valid && run_main && diff[18]) begin
            if (dsum >= QUANTUM) begin
               dacc_r <= dsum - QUANTUM;
               dcount_r <= dcount_r + 16'h0001;
            end else begin
               dacc_r <= dsum;
            end
         end
         if (sense_valid && run_main && !diff[18]) begin
            if (csum >= QUANTUM) begin
               cacc_r <= csum - QUANTUM;
               ccount_r <= ccount_r + 16'h0001;
            end else begin
               cacc_r <= csum;
            end
         end
         if (clr_r[`CCM_CLR_DCR]) begin
            dcount_r <= 16'h0000;
            dacc_r <= 32'h0000_0000;
         end
         if (clr_r[`CCM_CLR_CCR]) begin
            ccount_r <= 16'h0000;
            cacc_r <= 32'h0000_0000;
         end
      end
   end

   // time and self-discharge counters, mode and clear registers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         dtime_r <= 16'h0000;
         ctime_r <= 16'h0000;
         ddiv_r <= 8'h00;
         cdiv_r <= 8'h00;
         sdcount_r <= 16'h0000;
         sddiv_r <= 16'h0000;
         clr_r <= 5'h00;
         mode_r <= 8'h00;
         fcmd_r <= 8'h00;
         fpa_r <= 8'h00;
         fpd_r <= 8'h00;
      end else begin
         clr_r <= wr_clr ? reg_wdata[4:0] : 5'h00;
         if (wr_mode) begin
            mode_r[7:6] <= reg_wdata[7:6];
            mode_r[3:1] <= reg_wdata[3:1];
            if (!reg_wdata[`CCM_MODE_POR]) begin
               mode_r[`CCM_MODE_POR] <= 1'b0;
            end
         end
         if (state_r[3] && !por_st_r) begin
            mode_r[`CCM_MODE_POR] <= 1'b1;
         end
         if (wr_fcmd) begin
            fcmd_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == `CCM_A_FPA) begin
            fpa_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == `CCM_A_FPD) begin
            fpd_r <= reg_wdata;
         end
         if (tick_r && run_main && dis_act_r) begin
            ddiv_r <= ddiv_r + 8'h01;
         end
         if (tick_r && run_main && chg_act_r) begin
            cdiv_r <= cdiv_r + 8'h01;
         end
         if (clr_r[`CCM_CLR_DTC]) begin
            dtime_r <= 16'h0000;
            ddiv_r <= 8'h00;
            mode_r[`CCM_MODE_SLD] <= 1'b0;
         end else if (d_step) begin
            dtime_r <= dtime_r + 16'h0001;
         end
         if (clr_r[`CCM_CLR_CTC]) begin
            ctime_r <= 16'h0000;
            cdiv_r <= 8'h00;
            mode_r[`CCM_MODE_SLC] <= 1'b0;
         end else if (c_step) begin
            ctime_r <= ctime_r + 16'h0001;
         end
         if (d_step && dtime_r == `CCM_CNT_MAX) begin
            mode_r[`CCM_MODE_SLD] <= 1'b1;
         end
         if (c_step && ctime_r == `CCM_CNT_MAX) begin
            mode_r[`CCM_MODE_SLC] <= 1'b1;
         end
         if (clr_r[`CCM_CLR_SCR]) begin
            sdcount_r <= 16'h0000;
            sddiv_r <= 16'h0000;
         end else if (tick_r && run_sd) begin
            if (sddiv_r + 16'h0001 >= sd_period) begin
               sddiv_r <= 16'h0000;
               sdcount_r <= sdcount_r + 16'h0001;
            end else begin
               sddiv_r <= sddiv_r + 16'h0001;
            end
         end
      end
   end

   // converter results; ram keeps contents through hibernate
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         volt_r <= 11'h000;
         vofs_r <= 5'h00;
         temp_r <= `CCM_K_25C;
      end else begin
         if (cell_voltage_valid && !state_r[3]) begin
            volt_r <= cell_voltage_input;
            vofs_r <= cell_voltage_ofs;
         end
         if (die_temp_valid && !state_r[3]) begin
            temp_r <= die_temp_in;
         end
      end
   end

   always @(posedge clk) begin
      if (reg_wr && reg_addr <= `CCM_A_RAM_TOP) begin
         ram_r[reg_addr[4:0]] <= reg_wdata;
      end
   end

   // read decode over the 128-location space
   always @* begin
      rd_nxt = 8'h00;
      if (reg_addr <= `CCM_A_RAM_TOP) begin
         rd_nxt = ram_r[reg_addr[4:0]];
      end else if (reg_addr <= `CCM_A_FLASH_TOP) begin
         rd_nxt = `CCM_ERASED;
      end else if (reg_addr == `CCM_A_TEMPL) begin
         rd_nxt = temp_r[7:0];
      end else if (reg_addr == `CCM_A_TEMPH) begin
         rd_nxt = {5'h00, temp_r[10:8]};
      end else if (reg_addr == `CCM_A_FCMD) begin
         rd_nxt = fcmd_r;
      end else if (reg_addr == `CCM_A_CLR) begin
         rd_nxt = {3'h0, clr_r};
      end else if (reg_addr == `CCM_A_MODE) begin
         rd_nxt = {mode_r[7], state_r[0], mode_r[5:0]};
      end else if (reg_addr == `CCM_A_CTCL) begin
         rd_nxt = ctime_r[7:0];
      end else if (reg_addr == `CCM_A_CTCH) begin
         rd_nxt = ctime_r[15:8];
      end else if (reg_addr == `CCM_A_DTCL) begin
         rd_nxt = dtime_r[7:0];
      end else if (reg_addr == `CCM_A_DTCH) begin
         rd_nxt = dtime_r[15:8];
      end else if (reg_addr == `CCM_A_SCRL) begin
         rd_nxt = sdcount_r[7:0];
      end else if (reg_addr == `CCM_A_SCRH) begin
         rd_nxt = sdcount_r[15:8];
      end else if (reg_addr == `CCM_A_CCRL) begin
         rd_nxt = ccount_r[7:0];
      end else if (reg_addr == `CCM_A_CCRH) begin
         rd_nxt = ccount_r[15:8];
      end else if (reg_addr == `CCM_A_DCRL) begin
         rd_nxt = dcount_r[7:0];
      end else if (reg_addr == `CCM_A_DCRH) begin
         rd_nxt = dcount_r[15:8];
      end else if (reg_addr == `CCM_A_FPD) begin
         rd_nxt = fpd_r;
      end else if (reg_addr == `CCM_A_FPA) begin
         rd_nxt = fpa_r;
      end else if (reg_addr == `CCM_A_CELL_VOLTAGE_LOW) begin
         rd_nxt = volt_r[7:0];
      end else if (reg_addr == `CCM_A_CELL_VOLTAGE_HIGH_OFFSET) begin
         rd_nxt = {vofs_r, volt_r[10:8]};
      end else if (reg_addr <= `CCM_A_RSV_TOP) begin
         rd_nxt = 8'h00;
      end else begin
         case (reg_addr[2:0])
            3'h0: rd_nxt = ID_RANDOM[7:0];
            3'h1: rd_nxt = ID_GAIN;
            3'h2: rd_nxt = ID_RANDOM[15:8];
            3'h3: rd_nxt = ID_RANDOM[23:16];
            3'h4: rd_nxt = ID_RANDOM[31:24];
            3'h5: rd_nxt = ID_RANDOM[39:32];
            3'h6: rd_nxt = 8'h00;
            default: rd_nxt = ID_DEVICE;
         endcase
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end
   end
endmodule // ccm_core
`default_nettype wire

// file: sim/ccm_core_props.sv
// port checker for the coulomb counter monitor core
`default_nettype none
module ccm_core_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic por_in,
   input wire logic single_wire_serial_line,
   input wire logic [10:0] cell_voltage_input,
   input wire logic cell_voltage_valid,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic in_sleep,
   input wire logic in_hibernate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   wire rd_only = reg_rd && !reg_wr;
   sequence clr_rd;
      (reg_wr && reg_addr == 7'h63 && reg_wdata[4:0] != 5'h00) ##1 !reg_wr
         ##1 (rd_only && reg_addr == 7'h63);
   endsequence
   sequence dtc_clr_rd;
      (reg_wr && reg_addr == 7'h63 && reg_wdata[3]) ##1 !reg_wr
         ##1 (rd_only && reg_addr == 7'h67);
   endsequence
   sequence bat_rd;
      (cell_voltage_valid && !in_hibernate) ##1 !cell_voltage_valid
         ##1 (rd_only && !cell_voltage_valid && reg_addr == 7'h71);
   endsequence
   sequence por_rd;
      ($fell(in_hibernate) && !reg_wr) ##1 (rd_only && reg_addr == 7'h64);
   endsequence
   hib_entry_a: assert property (por_in [*8] |-> in_hibernate)
      else $error("hibernate not entered");
   hib_exit_a: assert property (!por_in [*8] |-> !in_hibernate)
      else $error("hibernate not left");
   por_flag_a: assert property (por_rd |=> reg_rdata[0])
      else $error("power-on flag not set");
   line_wake_a: assert property (in_sleep && $changed(single_wire_serial_line)
      |-> ##[1:10] !in_sleep) else $error("no wake on line edge");
   sleep_hib_a: assert property (in_hibernate |-> !in_sleep)
      else $error("sleep and hibernate together");
   clr_self_a: assert property (clr_rd |=> reg_rdata[4:0] == 5'h00)
      else $error("clear bits stuck");
   dtc_clear_a: assert property (dtc_clr_rd |=> reg_rdata == 8'h00)
      else $error("time counter not cleared");
   bat_low_a: assert property (bat_rd |=> reg_rdata == $past(cell_voltage_input[7:0], 3))
      else $error("voltage low byte wrong");
   rsv_zero_a: assert property (reg_rd && reg_addr inside {[7'h73:7'h77]}
      |=> reg_rdata == 8'h00) else $error("reserved not zero");
   flash_ff_a: assert property (reg_rd && reg_addr inside {[7'h20:7'h5F]}
      |=> reg_rdata == 8'hFF) else $error("flash not erased value");
endmodule // ccm_core_props
bind ccm_core ccm_core_props ccm_core_props_i (
   .clk(clk),
   .reset(reset),
   .por_in(por_in),
   .single_wire_serial_line(single_wire_serial_line),
   .cell_voltage_input(cell_voltage_input),
   .cell_voltage_valid(cell_voltage_valid),
   .reg_addr(reg_addr),
   .reg_wr(reg_wr),
   .reg_wdata(reg_wdata),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .in_sleep(in_sleep),
   .in_hibernate(in_hibernate)
);
`default_nettype wire

// file: sim/ccm_host.sv
// host model: register port and serial line of the monitor core
`default_nettype none
module ccm_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [6:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   output logic single_wire_serial_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      single_wire_serial_line = 1'b1;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
   task automatic go_sleep();
      wr(7'h62, 8'h45);
      wr(7'h62, 8'hF6);
   endtask
   task automatic line_edge();
      @(posedge clk);
      #1;
      single_wire_serial_line = ~single_wire_serial_line;
   endtask
endmodule // ccm_host
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the coulomb counter monitor core
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic por_in = 1'b1;
   logic [17:0] sense_sample = 18'h0_0000;
   logic sense_valid = 1'b0;
   logic [17:0] sense_zero = 18'h0_0007;
   logic sense_zero_valid = 1'b0;
   logic [10:0] cell_voltage_input = 11'h5A3;
   logic [4:0] cell_voltage_ofs = 5'h15;
   logic cell_voltage_valid = 1'b0;
   logic [10:0] die_temp_in = 11'h12C;
   logic die_temp_valid = 1'b0;
   wire [6:0] reg_addr;
   wire reg_wr;
   wire [7:0] reg_wdata;
   wire reg_rd;
   wire [7:0] reg_rdata;
   wire in_sleep;
   wire in_hibernate;
   wire single_wire_serial_line;
   logic [7:0] d;
   int n_fail = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   ccm_core #(.TICK_CYCLES(32'h0000_0001), .QUANTUM(32'h0000_0064), .ID_GAIN(8'h0A)) ccm_core_i (
      .clk(clk),
      .reset(reset),
      .por_in(por_in),
      .single_wire_serial_line(single_wire_serial_line),
      .sense_sample(sense_sample),
      .sense_valid(sense_valid),
      .sense_zero(sense_zero),
      .sense_zero_valid(sense_zero_valid),
      .cell_voltage_input(cell_voltage_input),
      .cell_voltage_ofs(cell_voltage_ofs),
      .cell_voltage_valid(cell_voltage_valid),
      .die_temp_in(die_temp_in),
      .die_temp_valid(die_temp_valid),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .in_sleep(in_sleep),
      .in_hibernate(in_hibernate)
   );
   ccm_host ccm_host_i (
      .clk(clk),
      .reg_rdata(reg_rdata),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .single_wire_serial_line(single_wire_serial_line)
   );
   task automatic give_verdict();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic chk(input logic [6:0] a, input logic [7:0] exp, input string what);
      logic [7:0] x;
      ccm_host_i.rd(a, x);
      cmp8(what, exp, x);
   endtask
   task automatic wait_lvl(input logic slp, input logic v, input string what);
      n_compared++;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if ((slp ? in_sleep : in_hibernate) === v)
            return;
      end
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, v, slp ? in_sleep : in_hibernate);
      give_verdict();
   endtask
   task automatic send(input logic [17:0] v, input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         sense_sample = v;
         sense_valid = 1'b1;
         @(posedge clk);
         #1;
         sense_valid = 1'b0;
      end
   endtask
   // two reads n cycles apart; the bench ticks the timebase every cycle
   task automatic tdiff(input logic [6:0] a, input logic [7:0] exp, input string what,
         input int n);
      logic [7:0] x;
      logic [7:0] y;
      ccm_host_i.rd(a, x);
      repeat (n - 2) @(posedge clk);
      ccm_host_i.rd(a, y);
      cmp8(what, exp, y - x);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      cmp8("hibernate", 8'h01, {7'h00, in_hibernate});
      ccm_host_i.wr(7'h05, 8'h3C);
      por_in = 1'b0;
      wait_lvl(1'b0, 1'b0, "hibernate exit");
      ccm_host_i.rd(7'h64, d);
      cmp8("mode", 8'h41, d & 8'h41);
      @(posedge clk);
      #1;
      cell_voltage_valid = 1'b1;
      die_temp_valid = 1'b1;
      sense_zero_valid = 1'b1;
      @(posedge clk);
      #1;
      cell_voltage_valid = 1'b0;
      die_temp_valid = 1'b0;
      sense_zero_valid = 1'b0;
      chk(7'h71, 8'hA3, "volt low");
      chk(7'h72, 8'hAD, "volt high");
      chk(7'h60, 8'h2C, "temp low");
      chk(7'h61, 8'h01, "temp high");
      chk(7'h79, 8'h0A, "gain");
      chk(7'h75, 8'h00, "reserved");
      chk(7'h30, 8'hFF, "flash");
      chk(7'h05, 8'h3C, "ram");
      ccm_host_i.wr(7'h63, 8'h1F);
      chk(7'h63, 8'h00, "clear bits");
      send(18'h3_FFD5, 10);
      ccm_host_i.wr(7'h6D, 8'hFF);
      chk(7'h6D, 8'h05, "dcount");
      chk(7'h6B, 8'h00, "ccount idle");
      tdiff(7'h67, 8'h28, "dtime", 40);
      tdiff(7'h65, 8'h00, "ctime idle", 40);
      send(18'h0_0020, 8);
      chk(7'h6B, 8'h02, "ccount");
      chk(7'h6D, 8'h05, "dcount idle");
      tdiff(7'h65, 8'h28, "ctime", 40);
      send(18'h0_0007, 4);
      chk(7'h6B, 8'h02, "zero diff");
      send(18'h3_FFD5, 1);
      tdiff(7'h69, 8'h10, "self-discharge", 65536);
      ccm_host_i.rd(7'h64, d);
      cmp8("slow flag set", 8'h10, d & 8'h30);
      ccm_host_i.wr(7'h63, 8'h08);
      chk(7'h67, 8'h00, "dtime clear");
      ccm_host_i.rd(7'h64, d);
      cmp8("slow flags", 8'h00, d & 8'h30);
      ccm_host_i.wr(7'h64, 8'h0E);
      send(18'h0_03EF, 1);
      ccm_host_i.go_sleep();
      repeat (30) @(posedge clk);
      #1;
      cmp8("busy sleep", 8'h00, {7'h00, in_sleep});
      ccm_host_i.line_edge();
      repeat (10) @(posedge clk);
      send(18'h0_0020, 1);
      ccm_host_i.wr(7'h64, 8'h02);
      ccm_host_i.go_sleep();
      wait_lvl(1'b1, 1'b1, "sleep entry");
      send(18'h3_FC1F, 20);
      tdiff(7'h67, 8'h00, "dtime asleep", 40);
      tdiff(7'h69, 8'h01, "self-discharge asleep", 4096);
      ccm_host_i.line_edge();
      wait_lvl(1'b1, 1'b0, "wake");
      chk(7'h6D, 8'h05, "sleep frozen");
      por_in = 1'b1;
      wait_lvl(1'b0, 1'b1, "hibernate entry");
      send(18'h3_FC1F, 5);
      chk(7'h6D, 8'h05, "hibernate frozen");
      chk(7'h05, 8'h3C, "ram kept");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
